// ### rtl/twc_consts.svh
`ifndef TWC_CONSTS_SVH
`define TWC_CONSTS_SVH
// ==========================================
// Register indexes, byte address is four times the index
`define TWC_IDX_CTRL_A 8'h80
`define TWC_IDX_CTRL_B 8'h81
`define TWC_IDX_COUNT 8'h84
`define TWC_IDX_CAPTURE 8'h86
`define TWC_IDX_CMP_A 8'h88
`define TWC_IDX_CMP_B 8'h8a
`define TWC_IDX_STATUS 8'h90
`define TWC_IDX_CLEAR 8'h91
`define TWC_IDX_ENABLE 8'h92
`define TWC_IDX_PIN_DIR 8'h93
// ==========================================
// Reset values and writable masks
`define TWC_CTRL_RST 8'h00
`define TWC_CTRL_A_MASK 8'hf3
`define TWC_CTRL_B_MASK 8'hdf
// ==========================================
// Field positions
`define TWC_A_COM_A 7:6
`define TWC_A_COM_B 5:4
`define TWC_A_WGM_LO 1:0
`define TWC_B_FILT 7
`define TWC_B_EDGE 6
`define TWC_B_WGM_HI 4:3
`define TWC_B_CS 2:0
`define TWC_ST_OVF 0
`define TWC_ST_MATCH_A 1
`define TWC_ST_MATCH_B 2
`define TWC_ST_CAP 3
// ==========================================
// Output modes, TOP values, clock selects
`define TWC_COM_OFF 2'h0
`define TWC_COM_TOGGLE 2'h1
`define TWC_COM_CLEAR 2'h2
`define TWC_COM_SET 2'h3
`define TWC_TOP_MAX 16'hffff
`define TWC_TOP_8 16'h00ff
`define TWC_TOP_9 16'h01ff
`define TWC_TOP_10 16'h03ff
`define TWC_BOTTOM 16'h0000
`define TWC_ONE 16'h0001
`define TWC_CS_STOP 3'h0
`define TWC_CS_DIV1 3'h1
`define TWC_CS_DIV8 3'h2
`define TWC_CS_DIV64 3'h3
`define TWC_CS_DIV256 3'h4
`define TWC_CS_DIV1024 3'h5
`define TWC_CS_EXT_FALL 3'h6
`define TWC_CS_EXT_RISE 3'h7
`define TWC_PRE_8 10'h007
`define TWC_PRE_64 10'h03f
`define TWC_PRE_256 10'h0ff
`define TWC_PRE_1024 10'h3ff
`endif

// ### rtl/twc_pkg.sv
package twc_pkg;
    typedef enum logic [2:0] {
        twc_k_normal = 3'b000,
        twc_k_ctc = 3'b001,
        twc_k_fast = 3'b010,
        twc_k_pc = 3'b011,
        twc_k_pfc = 3'b100,
        twc_k_rsvd = 3'b101
    } twc_kind_t;

    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [15:0] cnt;
        logic count_up;
        logic [9:0] pre;
        logic [15:0] cmp_a_buf;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b_buf;
        logic [15:0] cmp_b;
        logic [15:0] capture;
        logic [3:0] status;
        logic [3:0] enable;
        logic [1:0] pin_dir;
        logic [1:0] ext_sync;
        logic ext_prev;
        logic [1:0] cap_sync;
        logic [3:0] cap_hist;
        logic cap_level;
        logic cap_prev;
        logic wave_a;
        logic wave_b;
        logic pin_a;
        logic pin_b;
        logic oe_a;
        logic oe_b;
        logic irq;
        logic waitreq;
        logic [31:0] rdata;
    } twc_state_t;
endpackage

// ### rtl/twc_timer.sv
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`include "twc_consts.svh"
module twc_timer
    import twc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [9:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic chan_a_port_data_in,
    input wire logic chan_b_port_data_in,
    input wire logic ext_clk_pin_in,
    input wire logic capture_in_pin_in,
    output logic chan_a_wave_pin_out,
    output logic chan_a_wave_pin_oe_out,
    output logic chan_b_wave_pin_out,
    output logic chan_b_wave_pin_oe_out,
    output logic irq_out
);
    twc_state_t st_reg;
    twc_state_t st_next;
    twc_kind_t kind;
    logic [3:0] wgm;
    logic [15:0] top;
    logic tick;
    logic match_a;
    logic match_b;
    logic at_bottom;
    logic cap_is_top;
    logic cap_evt;
    logic wr_go;
    logic rd_go;
    logic conn_a;
    logic conn_b;
    logic tog_a;
    logic tog_b;
    logic [7:0] idx;

    // ==========================================
    // Waveform step for one channel
    function automatic logic wave_step(input logic [1:0] com, input twc_kind_t k, input logic tog_ok,
                                       input logic w, input logic hit, input logic bot, input logic up,
                                       input logic cmp_top);
        logic r;
        r = w;
        case (k)
            twc_k_normal, twc_k_ctc: begin
                if (hit) begin
                    case (com)
                        `TWC_COM_TOGGLE: r = ~w;
                        `TWC_COM_CLEAR: r = 1'b0;
                        `TWC_COM_SET: r = 1'b1;
                        default: r = w;
                    endcase
                end
            end
            twc_k_fast: begin
                if (com == `TWC_COM_TOGGLE) begin
                    if (hit && tog_ok) begin
                        r = ~w;
                    end
                end else if (com[1]) begin
                    if (hit && !cmp_top) begin
                        r = (com == `TWC_COM_SET);
                    end else if (bot) begin
                        r = (com != `TWC_COM_SET);
                    end
                end
            end
            twc_k_pc, twc_k_pfc: begin
                if (com == `TWC_COM_TOGGLE) begin
                    if (hit && tog_ok) begin
                        r = ~w;
                    end
                end else if (com[1] && hit) begin
                    r = (com == `TWC_COM_SET) ? up : ~up;
                end
            end
            default: r = w;
        endcase
        return r;
    endfunction

    // ==========================================
    // Next state
    always_comb begin
        st_next = st_reg;
        idx = avs_address_in[9:2];
        rd_go = avs_read_in && st_reg.waitreq;
        // Write lands at the edge where the master sees waitrequest low
        wr_go = avs_write_in && !st_reg.waitreq && avs_byteenable_in[0];
        wgm = {st_reg.ctrl_b[`TWC_B_WGM_HI], st_reg.ctrl_a[`TWC_A_WGM_LO]};
        case (wgm)
            4'h0: begin kind = twc_k_normal; top = `TWC_TOP_MAX; end
            4'h1: begin kind = twc_k_pc; top = `TWC_TOP_8; end
            4'h2: begin kind = twc_k_pc; top = `TWC_TOP_9; end
            4'h3: begin kind = twc_k_pc; top = `TWC_TOP_10; end
            4'h4: begin kind = twc_k_ctc; top = st_reg.cmp_a; end
            4'h5: begin kind = twc_k_fast; top = `TWC_TOP_8; end
            4'h6: begin kind = twc_k_fast; top = `TWC_TOP_9; end
            4'h7: begin kind = twc_k_fast; top = `TWC_TOP_10; end
            4'h8: begin kind = twc_k_pfc; top = st_reg.capture; end
            4'h9: begin kind = twc_k_pfc; top = st_reg.cmp_a; end
            4'ha: begin kind = twc_k_pc; top = st_reg.capture; end
            4'hb: begin kind = twc_k_pc; top = st_reg.cmp_a; end
            4'hc: begin kind = twc_k_ctc; top = st_reg.capture; end
            4'he: begin kind = twc_k_fast; top = st_reg.capture; end
            4'hf: begin kind = twc_k_fast; top = st_reg.cmp_a; end
            default: begin kind = twc_k_rsvd; top = `TWC_TOP_MAX; end
        endcase
        cap_is_top = (wgm == 4'h8) || (wgm == 4'ha) || (wgm == 4'hc) || (wgm == 4'he);

        // Prescaler runs free; the counter steps on the selected tick
        st_next.pre = st_reg.pre + 10'h001;
        st_next.ext_sync = {st_reg.ext_sync[0], ext_clk_pin_in};
        st_next.ext_prev = st_reg.ext_sync[1];
        case (st_reg.ctrl_b[`TWC_B_CS])
            `TWC_CS_STOP: tick = 1'b0;
            `TWC_CS_DIV1: tick = 1'b1;
            `TWC_CS_DIV8: tick = (st_reg.pre & `TWC_PRE_8) == `TWC_PRE_8;
            `TWC_CS_DIV64: tick = (st_reg.pre & `TWC_PRE_64) == `TWC_PRE_64;
            `TWC_CS_DIV256: tick = (st_reg.pre & `TWC_PRE_256) == `TWC_PRE_256;
            `TWC_CS_DIV1024: tick = st_reg.pre == `TWC_PRE_1024;
            `TWC_CS_EXT_FALL: tick = st_reg.ext_prev && !st_reg.ext_sync[1];
            default: tick = !st_reg.ext_prev && st_reg.ext_sync[1];
        endcase
        if (kind == twc_k_rsvd) begin
            tick = 1'b0;
        end

        match_a = tick && (st_reg.cnt == st_reg.cmp_a);
        match_b = tick && (st_reg.cnt == st_reg.cmp_b);
        at_bottom = 1'b0;

        // ==========================================
        // Counting sequence, buffer loads and wrap flag
        if (tick) begin
            case (kind)
                twc_k_normal, twc_k_ctc: begin
                    st_next.cnt = (kind == twc_k_ctc && st_reg.cnt == top) ? `TWC_BOTTOM : st_reg.cnt + `TWC_ONE;
                    if (st_reg.cnt == `TWC_TOP_MAX) begin
                        st_next.status[`TWC_ST_OVF] = 1'b1;
                    end
                end
                twc_k_fast: begin
                    if (st_reg.cnt == top) begin
                        st_next.cnt = `TWC_BOTTOM;
                        at_bottom = 1'b1;
                        st_next.status[`TWC_ST_OVF] = 1'b1;
                        st_next.cmp_a = st_reg.cmp_a_buf;
                        st_next.cmp_b = st_reg.cmp_b_buf;
                    end else begin
                        st_next.cnt = st_reg.cnt + `TWC_ONE;
                    end
                end
                default: begin
                    if (st_reg.count_up) begin
                        if (st_reg.cnt == top) begin
                            st_next.count_up = 1'b0;
                            st_next.cnt = st_reg.cnt - `TWC_ONE;
                            if (kind == twc_k_pc) begin
                                st_next.cmp_a = st_reg.cmp_a_buf;
                                st_next.cmp_b = st_reg.cmp_b_buf;
                            end
                        end else begin
                            st_next.cnt = st_reg.cnt + `TWC_ONE;
                        end
                    end else if (st_reg.cnt == `TWC_BOTTOM) begin
                        st_next.count_up = 1'b1;
                        st_next.cnt = `TWC_ONE;
                        st_next.status[`TWC_ST_OVF] = 1'b1;
                        if (kind == twc_k_pfc) begin
                            st_next.cmp_a = st_reg.cmp_a_buf;
                            st_next.cmp_b = st_reg.cmp_b_buf;
                        end
                    end else begin
                        st_next.cnt = st_reg.cnt - `TWC_ONE;
                    end
                end
            endcase
        end
        if (match_a) begin
            st_next.status[`TWC_ST_MATCH_A] = 1'b1;
        end
        if (match_b) begin
            st_next.status[`TWC_ST_MATCH_B] = 1'b1;
        end

        // ==========================================
        // Capture input: two-flop sync, optional filter, edge select
        st_next.cap_sync = {st_reg.cap_sync[0], capture_in_pin_in};
        st_next.cap_hist = {st_reg.cap_hist[2:0], st_reg.cap_sync[1]};
        if (!st_reg.ctrl_b[`TWC_B_FILT]) begin
            st_next.cap_level = st_reg.cap_sync[1];
        end else if (&st_reg.cap_hist) begin
            st_next.cap_level = 1'b1;
        end else if (~|st_reg.cap_hist) begin
            st_next.cap_level = 1'b0;
        end
        st_next.cap_prev = st_reg.cap_level;
        cap_evt = !cap_is_top && (st_reg.ctrl_b[`TWC_B_EDGE] ?
                  (st_reg.cap_level && !st_reg.cap_prev) : (!st_reg.cap_level && st_reg.cap_prev));
        if (cap_evt) begin
            st_next.capture = st_reg.cnt;
            st_next.status[`TWC_ST_CAP] = 1'b1;
        end

        // ==========================================
        // Bus slave: one wait cycle, then answer
        if (avs_read_in || avs_write_in) begin
            st_next.waitreq = !st_reg.waitreq;
        end else begin
            st_next.waitreq = 1'b1;
        end
        if (rd_go) begin
            case (idx)
                `TWC_IDX_CTRL_A: st_next.rdata = {24'h000000, st_reg.ctrl_a};
                `TWC_IDX_CTRL_B: st_next.rdata = {24'h000000, st_reg.ctrl_b};
                `TWC_IDX_COUNT: st_next.rdata = {16'h0000, st_reg.cnt};
                `TWC_IDX_CAPTURE: st_next.rdata = {16'h0000, st_reg.capture};
                `TWC_IDX_CMP_A: st_next.rdata = {16'h0000, st_reg.cmp_a_buf};
                `TWC_IDX_CMP_B: st_next.rdata = {16'h0000, st_reg.cmp_b_buf};
                `TWC_IDX_STATUS: st_next.rdata = {28'h0000000, st_reg.status};
                `TWC_IDX_ENABLE: st_next.rdata = {28'h0000000, st_reg.enable};
                `TWC_IDX_PIN_DIR: st_next.rdata = {30'h00000000, st_reg.pin_dir};
                default: st_next.rdata = 32'h00000000;
            endcase
        end
        if (wr_go) begin
            case (idx)
                `TWC_IDX_CTRL_A: st_next.ctrl_a = avs_writedata_in[7:0] & `TWC_CTRL_A_MASK;
                `TWC_IDX_CTRL_B: st_next.ctrl_b = avs_writedata_in[7:0] & `TWC_CTRL_B_MASK;
                `TWC_IDX_COUNT: st_next.cnt = avs_writedata_in[15:0];
                `TWC_IDX_CAPTURE: st_next.capture = avs_writedata_in[15:0];
                `TWC_IDX_CMP_A: st_next.cmp_a_buf = avs_writedata_in[15:0];
                `TWC_IDX_CMP_B: st_next.cmp_b_buf = avs_writedata_in[15:0];
                // Set wins: only flags not raised this cycle are cleared
                `TWC_IDX_CLEAR: st_next.status = st_next.status & (~avs_writedata_in[3:0] | (st_next.status &
                                                 ~st_reg.status));
                `TWC_IDX_ENABLE: st_next.enable = avs_writedata_in[3:0];
                `TWC_IDX_PIN_DIR: st_next.pin_dir = avs_writedata_in[1:0];
                default: st_next.rdata = st_reg.rdata;
            endcase
        end
        if (kind == twc_k_normal || kind == twc_k_ctc) begin
            st_next.cmp_a = st_next.cmp_a_buf;
            st_next.cmp_b = st_next.cmp_b_buf;
        end

        // ==========================================
        // Waveform generation and pin routing
        tog_a = (kind == twc_k_normal) || (kind == twc_k_ctc) ||
                ((kind == twc_k_fast) && (wgm == 4'he || wgm == 4'hf)) ||
                ((kind == twc_k_pc || kind == twc_k_pfc) && (wgm == 4'h9 || wgm == 4'hb));
        tog_b = (kind == twc_k_normal) || (kind == twc_k_ctc);
        st_next.wave_a = wave_step(st_reg.ctrl_a[`TWC_A_COM_A], kind, tog_a, st_reg.wave_a, match_a, at_bottom,
                                   st_reg.count_up, st_reg.cmp_a == top);
        st_next.wave_b = wave_step(st_reg.ctrl_a[`TWC_A_COM_B], kind, tog_b, st_reg.wave_b, match_b, at_bottom,
                                   st_reg.count_up, st_reg.cmp_b == top);
        // A toggle setting that the mode does not support leaves the pin with port logic
        conn_a = st_next.ctrl_a[`TWC_A_COM_A] != `TWC_COM_OFF &&
                 !(st_next.ctrl_a[`TWC_A_COM_A] == `TWC_COM_TOGGLE && !tog_a);
        conn_b = st_next.ctrl_a[`TWC_A_COM_B] != `TWC_COM_OFF &&
                 !(st_next.ctrl_a[`TWC_A_COM_B] == `TWC_COM_TOGGLE && !tog_b);
        st_next.pin_a = conn_a ? st_next.wave_a : chan_a_port_data_in;
        st_next.pin_b = conn_b ? st_next.wave_b : chan_b_port_data_in;
        st_next.oe_a = st_next.pin_dir[0];
        st_next.oe_b = st_next.pin_dir[1];
        st_next.irq = |(st_next.status & st_next.enable);
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
            st_reg.ctrl_a <= `TWC_CTRL_RST;
            st_reg.ctrl_b <= `TWC_CTRL_RST;
            st_reg.waitreq <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign avs_readdata_out = st_reg.rdata;
    assign avs_waitrequest_out = st_reg.waitreq;
    assign chan_a_wave_pin_out = st_reg.pin_a;
    assign chan_a_wave_pin_oe_out = st_reg.oe_a;
    assign chan_b_wave_pin_out = st_reg.pin_b;
    assign chan_b_wave_pin_oe_out = st_reg.oe_b;
    assign irq_out = st_reg.irq;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    port_when_off_a: assert property ((st_reg.ctrl_a[`TWC_A_COM_A] == `TWC_COM_OFF && !wr_go) |=>
        chan_a_wave_pin_out == $past(chan_a_port_data_in)) else $error("pin a not on port logic");
    driver_dir_a: assert property ((wr_go && idx == `TWC_IDX_PIN_DIR) |=>
        chan_a_wave_pin_oe_out == $past(avs_writedata_in[0])) else $error("pin a driver not per direction");
    nonpwm_toggle_a: assert property ((kind == twc_k_normal && match_a && !wr_go &&
        st_reg.ctrl_a[`TWC_A_COM_A] == `TWC_COM_TOGGLE) |=> st_reg.wave_a != $past(st_reg.wave_a))
        else $error("toggle on match missing");
    fast_bottom_set_a: assert property ((kind == twc_k_fast && tick && st_reg.cnt == top && !wr_go &&
        st_reg.ctrl_a[`TWC_A_COM_A] == `TWC_COM_CLEAR) |=> st_reg.wave_a) else $error("no set at bottom");
    top_match_skip_a: assert property ((kind == twc_k_fast && match_a && st_reg.cmp_a == top && !wr_go &&
        st_reg.ctrl_a[`TWC_A_COM_A] == `TWC_COM_SET) |=> !st_reg.wave_a) else $error("top match not ignored");
    dual_up_clear_a: assert property ((kind == twc_k_pc && match_a && st_reg.count_up && !wr_go &&
        st_reg.ctrl_a[`TWC_A_COM_A] == `TWC_COM_CLEAR) |=> !st_reg.wave_a) else $error("up match not cleared");
    filter_hold_a: assert property ((st_reg.ctrl_b[`TWC_B_FILT] && !(&st_reg.cap_hist) &&
        (|st_reg.cap_hist)) |=> $stable(st_reg.cap_level)) else $error("filter changed early");
    capture_copy_a: assert property (cap_evt |=> st_reg.capture == $past(st_reg.cnt) &&
        st_reg.status[`TWC_ST_CAP]) else $error("capture not taken");
    capture_off_a: assert property ((cap_is_top && !st_reg.status[`TWC_ST_CAP]) |=>
        !st_reg.status[`TWC_ST_CAP]) else $error("capture while register is top");
    stopped_count_a: assert property ((st_reg.ctrl_b[`TWC_B_CS] == `TWC_CS_STOP && !wr_go) |=>
        $stable(st_reg.cnt)) else $error("counter moved while stopped");
    bus_answer_a: assert property ((avs_read_in && avs_waitrequest_out) |=> !avs_waitrequest_out)
        else $error("no answer one cycle after request");

    wrap_seen_c: cover property (tick && kind == twc_k_fast && st_reg.cnt == top);
    capture_seen_c: cover property (cap_evt);
    dual_turn_c: cover property (kind == twc_k_pfc && tick && !st_reg.count_up && st_reg.cnt == `TWC_BOTTOM);
    irq_rise_c: cover property ($rose(irq_out));
endmodule

// ### dv/twc_pins_model.sv
`timescale 1ns/1ps
// ==========================================
// Pin side: capture source, external count pin, port data
module twc_pins_model (
    input wire logic clk_in,
    output logic cap_pin_out,
    output logic ext_clk_out,
    output logic port_a_out,
    output logic port_b_out
);
    // External count pin stands still: the bench only counts on the I/O clock
    initial begin
        cap_pin_out = 1'b0;
        ext_clk_out = 1'b0;
        port_a_out = 1'b1;
        port_b_out = 1'b1;
    end
    // Pins change only just after a rising edge, like a synchronous source
    task automatic drive(input logic cap, input logic pa);
        @(posedge clk_in);
        cap_pin_out <= cap;
        port_a_out <= pa;
    endtask
endmodule

// ### dv/tb_twc_timer.sv
`timescale 1ns/1ps
`include "twc_consts.svh"
// ==========================================
// Bench for the timer mode and capture control
module tb_twc_timer;
    logic clk_in, rst_n_in, avs_read_in, avs_write_in, avs_waitrequest_out, irq_out;
    logic [9:0] avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, rv, hi;
    logic [3:0] avs_byteenable_in;
    logic ext_clk_pin_in, capture_in_pin_in, chan_a_port_data_in, chan_b_port_data_in;
    logic chan_a_wave_pin_out, chan_a_wave_pin_oe_out, chan_b_wave_pin_out, chan_b_wave_pin_oe_out;
    int mismatches = 0;
    int checked = 0;
    // Waveform table: control A, control B, compare A, window, expected high cycles
    localparam logic [7:0] WA [9] = '{8'h81, 8'hc1, 8'h81, 8'h43, 8'h43, 8'h81, 8'hc1, 8'h41, 8'h43};
    localparam logic [7:0] WB [9] = '{8'h09, 8'h09, 8'h09, 8'h09, 8'h19, 8'h01, 8'h01, 8'h01, 8'h11};
    localparam logic [15:0] WC [9] = '{16'h0040, 16'h0040, 16'h00ff, 16'h0040, 16'h0040, 16'h0040, 16'h0040,
        16'h0040, 16'h0040};
    localparam int WW [9] = '{256, 256, 256, 256, 130, 510, 510, 256, 256};
    localparam logic [31:0] WH [9] = '{32'h41, 32'hbf, 32'h100, 32'h100, 32'h41, 32'h80, 32'h17e, 32'h100, 32'h80};
    // Capture table: control B, level, hold cycles, expected flag
    localparam logic [7:0] CB [7] = '{8'h41, 8'h41, 8'h01, 8'h01, 8'hc1, 8'hc1, 8'h59};
    localparam logic CL [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    // A pulse of two extra edges gives only three high samples, one short of the filter
    localparam int CW [7] = '{20, 20, 20, 20, 2, 20, 20};
    localparam logic CE [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

    twc_pins_model twc_pins_model_inst (.clk_in(clk_in), .cap_pin_out(capture_in_pin_in),
        .ext_clk_out(ext_clk_pin_in), .port_a_out(chan_a_port_data_in), .port_b_out(chan_b_port_data_in));
    twc_timer twc_timer_inst (.clk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
        .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .chan_a_port_data_in, .chan_b_port_data_in,
        .ext_clk_pin_in, .capture_in_pin_in, .chan_a_wave_pin_out, .chan_a_wave_pin_oe_out, .chan_b_wave_pin_out,
        .chan_b_wave_pin_oe_out, .irq_out);

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    // ==========================================
    // Shared tasks
    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Request held until waitrequest is sampled low; an extra edge keeps back to back calls apart
    task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
        int n;
        n = 0;
        avs_address_in <= {i, 2'b00};
        avs_writedata_in <= d;
        avs_write_in <= w;
        avs_read_in <= !w;
        do begin
            @(posedge clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 50);
        if (n >= 50) mismatches++;
        rv = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        bus(1'b1, i, d);
    endtask
    task automatic rchk(input logic [7:0] i, input string nm, input logic [31:0] exp);
        bus(1'b0, i, 32'h0);
        chk(nm, rv, exp);
    endtask
    task automatic measure(input int win);
        hi = 32'h0;
        repeat (win) begin
            @(posedge clk_in);
            hi = hi + (chan_a_wave_pin_out === 1'b1);
        end
    endtask
    // ==========================================
    // Scenarios
    task automatic t_regs();
        rchk(`TWC_IDX_CTRL_A, "ctrl_a reset", 32'h0);
        rchk(`TWC_IDX_CTRL_B, "ctrl_b reset", 32'h0);
        wr(`TWC_IDX_CTRL_B, 32'hff);
        rchk(`TWC_IDX_CTRL_B, "ctrl_b fields", 32'hdf);
        wr(`TWC_IDX_CTRL_B, 32'h0);
        rchk(8'h3f, "unmapped", 32'h0);
    endtask
    task automatic t_route();
        wr(`TWC_IDX_CMP_A, 32'h20);
        wr(`TWC_IDX_CMP_B, 32'h08);
        chk("oe_a off", chan_a_wave_pin_oe_out, 1'b0);
        wr(`TWC_IDX_PIN_DIR, 32'h3);
        wr(`TWC_IDX_CTRL_A, 32'h70);
        wr(`TWC_IDX_CTRL_B, 32'h09);
        repeat (100) @(posedge clk_in);
        measure(330);
        chk("ctc toggle", hi, 32'ha5);
        chk("ctc set b", chan_b_wave_pin_out, 1'b1);
        chk("oe_a on", chan_a_wave_pin_oe_out, 1'b1);
        wr(`TWC_IDX_CTRL_A, 32'h20);
        twc_pins_model_inst.drive(1'b0, 1'b0);
        repeat (40) @(posedge clk_in);
        chk("ctc clear b", chan_b_wave_pin_out, 1'b0);
        chk("port a low", chan_a_wave_pin_out, 1'b0);
        twc_pins_model_inst.drive(1'b0, 1'b1);
        repeat (4) @(posedge clk_in);
        chk("port a high", chan_a_wave_pin_out, 1'b1);
    endtask
    task automatic t_wave();
        for (int k = 0; k < 9; k++) begin
            wr(`TWC_IDX_CTRL_B, 32'h0);
            wr(`TWC_IDX_COUNT, 32'h0);
            wr(`TWC_IDX_CMP_A, {16'h0, WC[k]});
            wr(`TWC_IDX_CTRL_A, {24'h0, WA[k]});
            wr(`TWC_IDX_CTRL_B, {24'h0, WB[k]});
            repeat (1100) @(posedge clk_in);
            measure(WW[k]);
            chk("duty", hi, WH[k]);
        end
    endtask
    task automatic t_cap();
        wr(`TWC_IDX_CTRL_A, 32'h0);
        wr(`TWC_IDX_ENABLE, 32'h8);
        for (int k = 0; k < 7; k++) begin
            wr(`TWC_IDX_CTRL_B, {24'h0, CB[k]});
            twc_pins_model_inst.drive(!CL[k], 1'b1);
            repeat (12) @(posedge clk_in);
            wr(`TWC_IDX_CLEAR, 32'h8);
            twc_pins_model_inst.drive(CL[k], 1'b1);
            repeat (CW[k]) @(posedge clk_in);
            if (CW[k] < 8) twc_pins_model_inst.drive(!CL[k], 1'b1);
            repeat (12) @(posedge clk_in);
            chk("irq", irq_out, CE[k]);
            bus(1'b0, `TWC_IDX_STATUS, 32'h0);
            chk("cap flag", rv[3], CE[k]);
        end
        wr(`TWC_IDX_CTRL_B, 32'h41);
        // Park the counter away from both compare values, then drop stale wrap and match flags
        wr(`TWC_IDX_COUNT, 32'h100);
        wr(`TWC_IDX_CLEAR, 32'h7);
        twc_pins_model_inst.drive(1'b0, 1'b1);
        repeat (12) @(posedge clk_in);
        twc_pins_model_inst.drive(1'b1, 1'b1);
        repeat (12) @(posedge clk_in);
        wr(`TWC_IDX_ENABLE, 32'h0);
        chk("irq masked", irq_out, 1'b0);
        rchk(`TWC_IDX_STATUS, "sticky", 32'h8);
        wr(`TWC_IDX_CLEAR, 32'h8);
        rchk(`TWC_IDX_STATUS, "cleared", 32'h0);
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial begin
        rst_n_in = 1'b0;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_address_in = 10'h0;
        avs_writedata_in = 32'h0;
        avs_byteenable_in = 4'hf;
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        t_regs();
        t_route();
        t_wave();
        t_cap();
        test_done();
    end
    initial begin
        #200000;
        mismatches++;
        test_done();
    end
endmodule
